// [src/qsr_regs.sv]
// Control and status register slice of the quad serial flash controller
//
// The register offsets and the APB interface to the registers were decided locally.

// Behaviour
// - Threshold interrupt set once control buffer free space reaches threshold
// - Clock input delay code gives code plus one taps, 1 to 64
// - Data output delay code gives code plus one taps, 1 to 16
// - Clock output delay code gives code plus one taps, 1 to 16
// - Receive DMA state read-only in status bits 28 to 25
// - Receive FIFO byte count read-only in status bits 20 to 16
// - Current receive buffer length read-only in status bits 7 to 0
// - Threshold bits 31 to 5 read zero, writes ignored
module qsr_regs (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  input  wire qsr_pkg::qsr_rxstat_s  rx_status,
  input  wire logic [4:0]         ctrl_free_space,
  output qsr_pkg::qsr_tapcnt_s    tap_counts,
  output qsr_pkg::qsr_taps_s      tap_codes,
  output logic      [4:0]         ctrl_threshold,
  output logic                    irq
);
  import qsr_pkg::*;

  qsr_apb_e    apb_q;
  qsr_apb_e    apb_d;
  qsr_rxstat_s rxstat_q;
  logic [4:0]  thresh_q;
  qsr_taps_s   taps_q;
  logic [QSR_NIRQ-1:0] istat_q;
  logic [QSR_NIRQ-1:0] ien_q;
  logic [4:0]  space_q;
  logic        reached_q;
  logic        irq_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Decoding of the access phase
  wire acc     = psel && penable && !pready_q && ce;
  // Writes land on the edge where pready is seen high, not before
  wire wr      = psel && penable && pready_q && ce && pwrite;
  wire rd      = acc && !pwrite;
  wire hit_st  = paddr == QSR_OFF_RXSTAT;
  wire hit_th  = paddr == QSR_OFF_THRESH;
  wire hit_tp  = paddr == QSR_OFF_TAPS;
  wire hit_is  = paddr == QSR_OFF_ISTAT;
  wire hit_ic  = paddr == QSR_OFF_ICLR;
  wire hit_ie  = paddr == QSR_OFF_IEN;
  wire hit_sp  = paddr == QSR_OFF_SPACE;
  wire mapped  = hit_st | hit_th | hit_tp | hit_is | hit_ic | hit_ie
               | hit_sp;
  wire bad     = !mapped;

  // Threshold write takes only the low byte lane; upper bits not stored
  wire thr_we  = wr && hit_th && pstrb[0];
  wire tap_we0 = wr && hit_tp && pstrb[0];
  wire tap_we1 = wr && hit_tp && pstrb[1];
  wire ien_we  = wr && hit_ie && pstrb[0];
  wire clr_we  = wr && hit_ic && pstrb[0];

  // Level compare of free space against threshold
  wire reached = space_q >= thresh_q;
  // Edge into the reached condition raises the event
  wire th_evt  = reached && !reached_q;
  wire [QSR_NIRQ-1:0] clr_mask = clr_we ? pwdata[QSR_NIRQ-1:0] : '0;
  // Set wins over a clear in the same cycle
  wire [QSR_NIRQ-1:0] istat_d = (istat_q & ~clr_mask) | th_evt;

  function automatic logic [31:0] pack_status(input qsr_rxstat_s s);
    logic [31:0] w;
    w = '0;
    w[QSR_STATE_LSB +: 4]  = s.state;
    w[QSR_FIFO_LSB +: 5]   = s.fifo_count;
    w[QSR_BUFLEN_LSB +: 8] = s.buf_len;
    return w;
  endfunction

  wire [31:0] rd_status = pack_status(rxstat_q);
  wire [31:0] rd_thresh = {27'h0000000, thresh_q};
  wire [31:0] rd_taps   = {18'h00000, taps_q.clk_in, taps_q.data_out,
                           taps_q.clk_out};
  wire [31:0] rd_istat  = {{(32-QSR_NIRQ){1'b0}}, istat_q};
  wire [31:0] rd_ien    = {{(32-QSR_NIRQ){1'b0}}, ien_q};
  wire [31:0] rd_space  = {27'h0000000, space_q};
  wire [31:0] rd_mux    = hit_st ? rd_status :
                          hit_th ? rd_thresh :
                          hit_tp ? rd_taps   :
                          hit_is ? rd_istat  :
                          hit_ie ? rd_ien    :
                          hit_sp ? rd_space  : 32'h00000000;

  always_comb begin
    apb_d = apb_q;
    unique case (apb_q)
      QSR_IDLE:   if (psel && !penable) apb_d = QSR_ACCESS;
      QSR_ACCESS: if (pready_q) apb_d = QSR_IDLE;
    endcase
  end

  // Bus slave: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q     <= QSR_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (ce) begin
      apb_q     <= apb_d;
      pready_q  <= acc;
      pslverr_q <= acc && bad;
      if (rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Status fields follow the DMA engine only; bus writes never reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxstat_q <= '0;
    end else if (ce) begin
      rxstat_q <= rx_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_q <= QSR_THRESH_RST;
    end else if (ce && thr_we) begin
      thresh_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taps_q <= QSR_TAPS_RST;
    end else if (ce) begin
      if (tap_we0) begin
        taps_q.data_out <= pwdata[QSR_DOUT_LSB +: 4];
        taps_q.clk_out  <= pwdata[QSR_COUT_LSB +: 4];
      end
      if (tap_we1) begin
        taps_q.clk_in <= pwdata[QSR_CIN_LSB +: 6];
      end
    end
  end

  // Free space registered so the compare sees a clean value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_q   <= QSR_SPACE_RST;
      // Reset values already meet the compare; no false event after reset
      reached_q <= 1'b1;
    end else if (ce) begin
      space_q   <= ctrl_free_space;
      reached_q <= reached;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
      ien_q   <= QSR_IEN_RST;
      irq_q   <= 1'b0;
    end else if (ce) begin
      istat_q <= istat_d;
      if (ien_we) begin
        ien_q <= pwdata[QSR_NIRQ-1:0];
      end
      irq_q <= |(istat_d & (ien_we ? pwdata[QSR_NIRQ-1:0] : ien_q));
    end
  end

  qsr_tap_decode u_taps (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .codes    (taps_q),
    .counts_q (tap_counts)
  );

  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign prdata         = prdata_q;
  assign irq            = irq_q;
  assign ctrl_threshold = thresh_q;
  assign tap_codes      = taps_q;

  // Edge into reached sets the status bit next cycle
  thresh_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && th_evt |=> istat_q[0])
    else $error("threshold event did not set status");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $past(ce) |-> irq_q == $past(|(istat_d & (ien_we ?
      pwdata[QSR_NIRQ-1:0] : ien_q))))
    else $error("interrupt level wrong");

  clkin_tap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> tap_counts.clk_in == {1'b0, $past(taps_q.clk_in)} + 7'h01)
    else $error("clock input tap count wrong");

  dout_tap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> tap_counts.data_out == {1'b0, $past(taps_q.data_out)} + 5'h01)
    else $error("data output tap count wrong");

  cout_tap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> tap_counts.clk_out == {1'b0, $past(taps_q.clk_out)} + 5'h01)
    else $error("clock output tap count wrong");

  state_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_st |=> prdata_q[28:25] == $past(rxstat_q.state))
    else $error("receive state read wrong");

  fifo_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_st |=> prdata_q[20:16] == $past(rxstat_q.fifo_count)
      && prdata_q[24:21] == 4'h0)
    else $error("fifo count read wrong");

  buflen_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_st |=> prdata_q[7:0] == $past(rxstat_q.buf_len)
      && prdata_q[15:8] == 8'h00)
    else $error("buffer length read wrong");

  thr_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && hit_th |=> prdata_q[31:5] == 27'h0000000)
    else $error("threshold upper bits not zero");

  status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr && hit_st |=> rxstat_q == $past(rx_status))
    else $error("status changed by a write");

endmodule

// [src/qsr_pkg.sv]
// Package: register map, field layout, reset values and shared types
package qsr_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] QSR_OFF_RXSTAT  = 8'h00;
  localparam logic [7:0] QSR_OFF_THRESH  = 8'h04;
  localparam logic [7:0] QSR_OFF_TAPS    = 8'h08;
  localparam logic [7:0] QSR_OFF_ISTAT   = 8'h0C;
  localparam logic [7:0] QSR_OFF_ICLR    = 8'h10;
  localparam logic [7:0] QSR_OFF_IEN     = 8'h14;
  localparam logic [7:0] QSR_OFF_SPACE   = 8'h18;

  // Field positions
  localparam int QSR_STATE_LSB  = 25;
  localparam int QSR_FIFO_LSB   = 16;
  localparam int QSR_BUFLEN_LSB = 0;
  localparam int QSR_CIN_LSB    = 8;
  localparam int QSR_DOUT_LSB   = 4;
  localparam int QSR_COUT_LSB   = 0;

  // Reset values
  localparam logic [4:0]  QSR_THRESH_RST = 5'h00;
  localparam logic [13:0] QSR_TAPS_RST   = 14'h0000;
  localparam logic [0:0]  QSR_IEN_RST    = 1'h0;
  localparam logic [4:0]  QSR_SPACE_RST  = 5'h00;

  // Number of interrupt sources
  localparam int QSR_NIRQ = 1;

  // Receive DMA status captured from the DMA engine
  typedef struct packed {
    logic [3:0] state;
    logic [4:0] fifo_count;
    logic [7:0] buf_len;
  } qsr_rxstat_s;

  // Delay tap codes, each code means code plus one taps
  typedef struct packed {
    logic [5:0] clk_in;
    logic [3:0] data_out;
    logic [3:0] clk_out;
  } qsr_taps_s;

  // Tap counts after the plus-one offset
  typedef struct packed {
    logic [6:0] clk_in;
    logic [4:0] data_out;
    logic [4:0] clk_out;
  } qsr_tapcnt_s;

  typedef enum logic [1:0] {
    QSR_IDLE,
    QSR_ACCESS
  } qsr_apb_e;

endpackage

// [src/qsr_tap_decode.sv]
// Tap decoder: turns tap codes into registered tap counts
module qsr_tap_decode (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire qsr_pkg::qsr_taps_s   codes,
  output qsr_pkg::qsr_tapcnt_s   counts_q
);
  import qsr_pkg::*;

  qsr_tapcnt_s counts_d;

  assign counts_d.clk_in   = {1'b0, codes.clk_in} + 7'h01;
  assign counts_d.data_out = {1'b0, codes.data_out} + 5'h01;
  assign counts_d.clk_out  = {1'b0, codes.clk_out} + 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counts_q <= '0;
    end else if (ce) begin
      counts_q <= counts_d;
    end
  end

endmodule

// [testbench/qsr_dma_model.sv]
// Behavioural receive DMA side: drives status fields and control space
module qsr_dma_model
  import qsr_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire qsr_pkg::qsr_rxstat_s next_status,
  input  wire logic [4:0]          next_space,
  output qsr_pkg::qsr_rxstat_s     rx_status,
  output logic      [4:0]          ctrl_free_space
);
  // Levels move only on the clock edge, as the engine's registers would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status       <= '0;
      ctrl_free_space <= 5'h00;
    end else begin
      rx_status       <= next_status;
      ctrl_free_space <= next_space;
    end
  end
endmodule

// [testbench/quad_serial_flash_ctrl_status_regs_test.sv]
// Self-checking testbench for the flash controller register slice
module quad_serial_flash_ctrl_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import qsr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, w;
  logic        pready, pslverr, perr, irq;
  qsr_rxstat_s nst = '0, rx_status;
  logic [4:0]  nsp = 5'h00, space, thr;
  qsr_tapcnt_s tcnt;
  qsr_taps_s   tcod;
  logic [13:0] c;
  int          errors = 0, compares = 0, cycles = 0;

  qsr_dma_model i_dma (.pclk(pclk), .presetn(presetn), .next_status(nst),
    .next_space(nsp), .rx_status(rx_status), .ctrl_free_space(space));
  qsr_regs i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_status(rx_status), .ctrl_free_space(space), .tap_counts(tcnt),
    .tap_codes(tcod), .ctrl_threshold(thr), .irq(irq));

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bound sized far above the 48 transfers of a few cycles each
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled high, then releases it
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors = errors + 1;
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] exp_stat(qsr_rxstat_s s);
    return {3'h0, s.state, 4'h0, s.fifo_count, 8'h00, s.buf_len};
  endfunction

  function automatic logic [16:0] exp_cnt(logic [13:0] k);
    return {{1'b0, k[13:8]} + 7'h01, {1'b0, k[7:4]} + 5'h01,
            {1'b0, k[3:0]} + 5'h01};
  endfunction

  initial begin
    void'($urandom(55129));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("tap counts at reset", 32'(tcnt), 32'(exp_cnt(14'h0000)));
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom);
      apb(1'b1, QSR_OFF_TAPS, {$urandom, 18'h0} | 32'(c));
      apb(1'b0, QSR_OFF_TAPS, 32'h0);
      chk("tap readback", q, {18'h0, c});
      chk("clk in taps", 32'(tcnt.clk_in), 32'(exp_cnt(c) >> 10));
      chk("data out taps", 32'(tcnt.data_out),
          32'((exp_cnt(c) >> 5) & 17'h1F));
      chk("clk out taps", 32'(tcnt.clk_out), 32'(exp_cnt(c) & 17'h1F));
    end
    $display("tap test done");
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      apb(1'b1, QSR_OFF_THRESH, w);
      apb(1'b0, QSR_OFF_THRESH, 32'h0);
      chk("threshold readback", q, {27'h0, w[4:0]});
      chk("threshold out", 32'(thr), 32'(w[4:0]));
    end
    $display("threshold test done");
    for (int i = 0; i < 6; i++) begin
      nst <= (i == 0) ? qsr_rxstat_s'(17'h1FFFF)
                      : qsr_rxstat_s'(17'($urandom));
      repeat (3) @(posedge pclk);
      apb(1'b1, QSR_OFF_RXSTAT, $urandom);
      apb(1'b0, QSR_OFF_RXSTAT, 32'h0);
      chk("rx status", q, exp_stat(nst));
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'(perr), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("status test done");
    apb(1'b1, QSR_OFF_THRESH, 32'h0000000A);
    nsp <= 5'h03;
    repeat (4) @(posedge pclk);
    apb(1'b1, QSR_OFF_ICLR, 32'h1);
    apb(1'b1, QSR_OFF_IEN, 32'h1);
    chk("irq below threshold", 32'(irq), 32'h0);
    nsp <= 5'h09;
    repeat (4) @(posedge pclk);
    chk("irq one short", 32'(irq), 32'h0);
    nsp <= 5'h0A;
    repeat (4) @(posedge pclk);
    chk("irq at threshold", 32'(irq), 32'h1);
    apb(1'b0, QSR_OFF_ISTAT, 32'h0);
    chk("irq status", q, 32'h1);
    apb(1'b1, QSR_OFF_IEN, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, QSR_OFF_IEN, 32'h1);
    apb(1'b1, QSR_OFF_ICLR, 32'h1);
    @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("interrupt test done");
    wrap_up();
  end
endmodule
